// ---- common/scs_pkg.sv ----
// Functional notes
// - mode 0: both clock selects low gives port pin; low select 1 with high select 0 outputs clock.
// - mode 1 with both selects low drives clock pin constantly low.
// - mode 1, high select 1, low select 0 drives clock pin high.
// - mode 1 with low select 1 outputs the clock regardless.
// - smart card timing always uses the internal clock, never external.
// - error flag sets when card drives error signal low during transmission.
// - error flag clears only by writing 0 after reading 1.
// - clearing transmit enable leaves the error flag unchanged.
// - no framing error detection; status bit 4 reports error signal.
// - done flag clears on writing 0 to empty flag after reading 1.
// - done flag sets while transmit enable and error flag are both 0.
// - mode 0: done flag sets 2.5 etu after character, empty and no error.
// - mode 1: done flag sets 1.0 etu after character, empty and no error.
// - reset and standby set done and empty flags, clear error flag.
// - status bits 7..3 accept only written 0; done flag hardware only.
// - mode select is bit 7 of serial mode register.
// - smart card behaviour active only while smart card enable is 1.
// - clock output frequency is 372 times the bit rate.
package scs_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_CARDMODE = 8'h18;

    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_RATE = 8'hff;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TXDATA = 8'hff;
    localparam logic [7:0] RST_CARDMODE = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MODE_GSM_BIT = 7;
    localparam int CTRL_TE_BIT = 5;
    localparam int CTRL_CLOCK_OUT_SEL_HI_BIT = 1;
    localparam int CTRL_CLOCK_OUT_SEL_LO_BIT = 0;
    localparam int CARD_ENABLE_BIT = 0;
    localparam int STAT_TX_DATA_EMPTY_FLAG_BIT = 7;
    localparam int STAT_ERS_BIT = 4;
    localparam int STAT_TRANSMIT_DONE_FLAG_BIT = 2;
    localparam logic [7:0] CTRL_WMASK = 8'hf3;
    localparam logic [7:0] CARDMODE_WMASK = 8'h0d;

    // ****************************************
    // timing, in half-etu steps from start bit
    // ****************************************
    localparam int CLK_PER_ETU = 372;
    localparam logic [7:0] SCK_PER_HALF_ETU = 8'(CLK_PER_ETU / 2);
    localparam int FRAME_ETU = 10;
    localparam int GUARD_ETU = 2;
    localparam int TRANSMIT_DONE_FLAG_GM0_ETU_X10 = 25;
    localparam int TRANSMIT_DONE_FLAG_GM1_ETU_X10 = 10;
    localparam int RETRY_ETU = 4;
    localparam logic [4:0] HALF_FRAME_END = 5'(FRAME_ETU * 2);
    localparam logic [4:0] HALF_ERR_WIN = 5'(FRAME_ETU * 2 + 1);
    localparam logic [4:0] HALF_TRANSMIT_DONE_FLAG_GM0 = 5'(FRAME_ETU * 2 + TRANSMIT_DONE_FLAG_GM0_ETU_X10 / 5);
    localparam logic [4:0] HALF_TRANSMIT_DONE_FLAG_GM1 = 5'(FRAME_ETU * 2 + TRANSMIT_DONE_FLAG_GM1_ETU_X10 / 5);
    localparam logic [4:0] HALF_NEXT = 5'((FRAME_ETU + GUARD_ETU) * 2);
    localparam logic [4:0] HALF_RETRY = 5'((FRAME_ETU + RETRY_ETU) * 2);

    typedef enum logic [1:0] {TX_IDLE, TX_FRAME} scs_tx_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scs_req_s;

    typedef struct packed {
        logic out;
        logic oe;
    } scs_pin_s;

endpackage

// ---- hw/scs_sync.sv ----
module scs_sync (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic meta;
        logic stable;
    } scs_sync_s;

    scs_sync_s st_r;
    scs_sync_s st_nxt;

    always_comb begin
        st_nxt.meta = din;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.stable;

endmodule

// ---- hw/scs_ctrl.sv ----
// The implementer's own choices: the placing of the registers and strobed register access.
module scs_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic standby,
    input wire scs_pkg::scs_req_s req,
    output logic [7:0] rdata,
    input wire logic line_in,
    output scs_pkg::scs_pin_s line_pin,
    output scs_pkg::scs_pin_s sck_pin
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] rate;
        logic [7:0] ctrl;
        logic [7:0] txdata;
        logic [7:0] cardmode;
        logic tx_data_empty_flag;
        logic error_signal_flag;
        logic transmit_done_flag;
        logic seen_tx_data_empty_flag;
        logic seen_ers;
        scs_pkg::scs_tx_e tx;
        logic [4:0] half;
        logic [9:0] shift;
        logic [7:0] div_cnt;
        logic [7:0] sck_cnt;
        logic sck_lvl;
        logic [7:0] rdata;
        scs_pkg::scs_pin_s line;
        scs_pkg::scs_pin_s sck;
    } scs_state_s;

    scs_state_s st_r;
    scs_state_s st_nxt;
    logic line_sync;

    scs_sync u_line_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .din(line_in),
        .dout(line_sync)
    );

    // ****************************************
    // decoded controls
    // ****************************************
    logic gsm_mode_select;
    logic clock_out_sel_hi;
    logic clock_out_sel_lo;
    logic transmit_enable;
    logic smartcard_enable;
    logic [7:0] status_rd;

    always_comb begin
        gsm_mode_select = st_r.mode[scs_pkg::MODE_GSM_BIT];
        clock_out_sel_hi = st_r.ctrl[scs_pkg::CTRL_CLOCK_OUT_SEL_HI_BIT];
        clock_out_sel_lo = st_r.ctrl[scs_pkg::CTRL_CLOCK_OUT_SEL_LO_BIT];
        transmit_enable = st_r.ctrl[scs_pkg::CTRL_TE_BIT];
        smartcard_enable = st_r.cardmode[scs_pkg::CARD_ENABLE_BIT];
        status_rd = 8'h00;
        status_rd[scs_pkg::STAT_TX_DATA_EMPTY_FLAG_BIT] = st_r.tx_data_empty_flag;
        status_rd[scs_pkg::STAT_ERS_BIT] = st_r.error_signal_flag;
        status_rd[scs_pkg::STAT_TRANSMIT_DONE_FLAG_BIT] = st_r.transmit_done_flag;
    end

    // ****************************************
    // next state
    // ****************************************
    logic half_tick;
    logic sck_rise;
    logic stat_wr;
    logic [4:0] half_step;
    logic [4:0] transmit_done_flag_half;

    always_comb begin
        st_nxt = st_r;
        half_tick = 1'b0;
        sck_rise = 1'b0;
        stat_wr = req.wr && (req.addr == scs_pkg::ADDR_STAT);
        half_step = st_r.half + 5'h01;
        transmit_done_flag_half = gsm_mode_select ? scs_pkg::HALF_TRANSMIT_DONE_FLAG_GM1 : scs_pkg::HALF_TRANSMIT_DONE_FLAG_GM0;

        // baud generator: always internal, smart card mode only
        if (smartcard_enable) begin
            if (st_r.div_cnt == st_r.rate) begin
                st_nxt.div_cnt = 8'h00;
                st_nxt.sck_lvl = !st_r.sck_lvl;
                sck_rise = !st_r.sck_lvl;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 8'h01;
            end
            if (sck_rise) begin
                // half etu every 186 clock periods
                if (st_r.sck_cnt == scs_pkg::SCK_PER_HALF_ETU - 8'h01) begin
                    st_nxt.sck_cnt = 8'h00;
                    half_tick = 1'b1;
                end else begin
                    st_nxt.sck_cnt = st_r.sck_cnt + 8'h01;
                end
            end
        end else begin
            st_nxt.div_cnt = 8'h00;
            st_nxt.sck_cnt = 8'h00;
            st_nxt.sck_lvl = 1'b0;
        end

        // clock pin function
        st_nxt.sck = '{out: 1'b0, oe: 1'b0};
        if (smartcard_enable) begin
            if (!gsm_mode_select) begin
                if (!clock_out_sel_hi && clock_out_sel_lo) begin
                    st_nxt.sck = '{out: st_nxt.sck_lvl, oe: 1'b1};
                end
            end else if (clock_out_sel_lo) begin
                st_nxt.sck = '{out: st_nxt.sck_lvl, oe: 1'b1};
            end else if (clock_out_sel_hi) begin
                st_nxt.sck = '{out: 1'b1, oe: 1'b1};
            end else begin
                st_nxt.sck = '{out: 1'b0, oe: 1'b1};
            end
        end

        // register writes
        if (req.wr) begin
            case (req.addr)
                scs_pkg::ADDR_MODE: st_nxt.mode = req.wdata;
                scs_pkg::ADDR_RATE: st_nxt.rate = req.wdata;
                scs_pkg::ADDR_CTRL: st_nxt.ctrl = req.wdata & scs_pkg::CTRL_WMASK;
                scs_pkg::ADDR_TXDATA: st_nxt.txdata = req.wdata;
                scs_pkg::ADDR_CARDMODE: st_nxt.cardmode = req.wdata & scs_pkg::CARDMODE_WMASK;
                default: st_nxt.mode = st_nxt.mode;
            endcase
        end

        // read-one then write-zero clears
        if (stat_wr) begin
            if (!req.wdata[scs_pkg::STAT_TX_DATA_EMPTY_FLAG_BIT] && st_r.seen_tx_data_empty_flag) begin
                st_nxt.tx_data_empty_flag = 1'b0;
                st_nxt.transmit_done_flag = 1'b0;
            end
            if (!req.wdata[scs_pkg::STAT_ERS_BIT] && st_r.seen_ers) begin
                st_nxt.error_signal_flag = 1'b0;
            end
            st_nxt.seen_tx_data_empty_flag = 1'b0;
            st_nxt.seen_ers = 1'b0;
        end

        // register reads
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                scs_pkg::ADDR_MODE: st_nxt.rdata = st_r.mode;
                scs_pkg::ADDR_RATE: st_nxt.rdata = st_r.rate;
                scs_pkg::ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
                scs_pkg::ADDR_TXDATA: st_nxt.rdata = st_r.txdata;
                scs_pkg::ADDR_CARDMODE: st_nxt.rdata = st_r.cardmode;
                scs_pkg::ADDR_STAT: begin
                    st_nxt.rdata = status_rd;
                    st_nxt.seen_tx_data_empty_flag = st_r.tx_data_empty_flag;
                    st_nxt.seen_ers = st_r.error_signal_flag;
                end
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // transmitter
        case (st_r.tx)
            scs_pkg::TX_IDLE: begin
                st_nxt.line = '{out: 1'b1, oe: 1'b0};
                if (smartcard_enable && transmit_enable && !st_r.tx_data_empty_flag && !st_r.error_signal_flag) begin
                    st_nxt.shift = {^st_r.txdata, st_r.txdata, 1'b0};
                    st_nxt.tx_data_empty_flag = 1'b1;
                    st_nxt.tx = scs_pkg::TX_FRAME;
                    st_nxt.half = 5'h00;
                    st_nxt.sck_cnt = 8'h00;
                    st_nxt.line = '{out: 1'b0, oe: 1'b1};
                end
            end
            scs_pkg::TX_FRAME: begin
                // error signal sampled in the window after parity
                if (st_r.half == scs_pkg::HALF_ERR_WIN && !line_sync) begin
                    st_nxt.error_signal_flag = 1'b1;
                end
                if (half_tick) begin
                    st_nxt.half = half_step;
                    if (half_step < scs_pkg::HALF_FRAME_END) begin
                        st_nxt.line = '{out: st_r.shift[half_step[4:1]], oe: 1'b1};
                    end else begin
                        st_nxt.line = '{out: 1'b1, oe: 1'b0};
                    end
                    if (half_step == transmit_done_flag_half && st_nxt.tx_data_empty_flag && !st_r.error_signal_flag) begin
                        st_nxt.transmit_done_flag = 1'b1;
                    end
                    if (st_r.error_signal_flag) begin
                        // same character again after guard
                        if (half_step == scs_pkg::HALF_RETRY) begin
                            st_nxt.half = 5'h00;
                            st_nxt.line = '{out: 1'b0, oe: 1'b1};
                        end
                    end else if (half_step >= scs_pkg::HALF_NEXT && half_step >= transmit_done_flag_half) begin
                        st_nxt.tx = scs_pkg::TX_IDLE;
                    end else if (half_step == scs_pkg::HALF_NEXT && !st_nxt.tx_data_empty_flag && transmit_enable) begin
                        st_nxt.shift = {^st_r.txdata, st_r.txdata, 1'b0};
                        st_nxt.tx_data_empty_flag = 1'b1;
                        st_nxt.half = 5'h00;
                        st_nxt.line = '{out: 1'b0, oe: 1'b1};
                    end
                end
                if (!smartcard_enable) begin
                    st_nxt.tx = scs_pkg::TX_IDLE;
                    st_nxt.line = '{out: 1'b1, oe: 1'b0};
                end
            end
            default: begin
                st_nxt.tx = scs_pkg::TX_IDLE;
            end
        endcase

        // transmitter off and no error pending
        if (!transmit_enable && !st_r.error_signal_flag) begin
            st_nxt.transmit_done_flag = 1'b1;
        end
        if (!transmit_enable) begin
            st_nxt.tx = scs_pkg::TX_IDLE;
            st_nxt.line = '{out: 1'b1, oe: 1'b0};
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset || standby) begin
            st_r.mode <= scs_pkg::RST_MODE;
            st_r.rate <= scs_pkg::RST_RATE;
            st_r.ctrl <= scs_pkg::RST_CTRL;
            st_r.txdata <= scs_pkg::RST_TXDATA;
            st_r.cardmode <= scs_pkg::RST_CARDMODE;
            st_r.tx_data_empty_flag <= 1'b1;
            st_r.error_signal_flag <= 1'b0;
            st_r.transmit_done_flag <= 1'b1;
            st_r.seen_tx_data_empty_flag <= 1'b0;
            st_r.seen_ers <= 1'b0;
            st_r.tx <= scs_pkg::TX_IDLE;
            st_r.half <= 5'h00;
            st_r.shift <= 10'h000;
            st_r.div_cnt <= 8'h00;
            st_r.sck_cnt <= 8'h00;
            st_r.sck_lvl <= 1'b0;
            st_r.rdata <= 8'h00;
            st_r.line <= '{out: 1'b1, oe: 1'b0};
            st_r.sck <= '{out: 1'b0, oe: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign line_pin = st_r.line;
    assign sck_pin = st_r.sck;

endmodule

// ---- verif/scs_ctrl_props.sv ----
module scs_ctrl_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic standby,
    input wire scs_pkg::scs_req_s req,
    input wire logic [7:0] rdata,
    input wire logic line_in,
    input wire scs_pkg::scs_pin_s line_pin,
    input wire scs_pkg::scs_pin_s sck_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // shadow of the clock pin configuration
    // ****************************************
    logic gm_r, en_r, rate0_r;
    logic [1:0] cke_r, stab_r;
    wire cfg_ok = stab_r == 2'h3;
    always_ff @(posedge sys_clk) begin
        if (reset || standby) begin
            gm_r <= 1'b0;
            en_r <= 1'b0;
            rate0_r <= 1'b0;
            cke_r <= 2'h0;
            stab_r <= 2'h0;
        end else begin
            if (req.wr && req.addr == scs_pkg::ADDR_MODE) gm_r <= req.wdata[7];
            if (req.wr && req.addr == scs_pkg::ADDR_CARDMODE) en_r <= req.wdata[0];
            if (req.wr && req.addr == scs_pkg::ADDR_RATE) rate0_r <= req.wdata == 8'h00;
            if (req.wr && req.addr == scs_pkg::ADDR_CTRL) cke_r <= req.wdata[1:0];
            stab_r <= req.wr ? 2'h0 : (cfg_ok ? stab_r : stab_r + 2'h1);
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset || standby);
    AST_SCK_OFF: assert property (cfg_ok && !en_r |-> !sck_pin.oe)
        else $error("clock pin driven with smart card off");
    AST_SCK_PORT: assert property (cfg_ok && en_r && !gm_r && cke_r == 2'b00 |-> !sck_pin.oe)
        else $error("clock pin not a port pin");
    AST_SCK_LOW: assert property (cfg_ok && en_r && gm_r && cke_r == 2'b00 |-> sck_pin.oe && !sck_pin.out)
        else $error("clock pin not fixed low");
    AST_SCK_HIGH: assert property (cfg_ok && en_r && gm_r && cke_r == 2'b10 |-> sck_pin.oe && sck_pin.out)
        else $error("clock pin not fixed high");
    AST_SCK_RUN: assert property (cfg_ok && en_r && rate0_r && !req.wr && cke_r[0] && (gm_r || !cke_r[1])
        |=> sck_pin.oe && sck_pin.out != $past(sck_pin.out)) else $error("clock pin not toggling");
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset || standby
        |=> rdata == 8'h00 && !line_pin.oe && !sck_pin.oe) else $error("outputs active after reset");
    AST_RDATA_IDLE: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    AST_STAT_RSVD: assert property ($past(req.rd) && $past(req.addr) == scs_pkg::ADDR_STAT
        |-> (rdata & 8'h6b) == 8'h00) else $error("status unused bits set");
    AST_LINE_IDLE: assert property (cfg_ok && !en_r |-> !line_pin.oe)
        else $error("data line driven with smart card off");
    cover property (cfg_ok && en_r && gm_r && cke_r == 2'b10);
    cover property (line_pin.oe && !line_pin.out);
    cover property ($past(req.rd) && rdata[4]);
endmodule

bind scs_ctrl scs_ctrl_props u_scs_ctrl_props (.sys_clk(sys_clk), .reset(reset), .standby(standby),
    .req(req), .rdata(rdata), .line_in(line_in), .line_pin(line_pin), .sck_pin(sck_pin));

// ---- verif/scs_card.sv ----
module scs_card #(
    parameter int ETU = 744
) (
    input wire logic sys_clk,
    input wire logic line,
    input wire logic err_req,
    output logic pull_low
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic busy = 1'b0;
    initial pull_low = 1'b0;
    // frame timing counted from the start bit edge
    always @(posedge sys_clk) begin
        if (!busy) begin
            if (line === 1'b0) begin
                busy <= 1'b1;
                cnt <= 1;
            end
        end else begin
            cnt <= cnt + 1;
            if (cnt >= ETU * 12) busy <= 1'b0;
        end
        // error signal, 1 etu low from 10.5 etu
        pull_low <= busy && err_req && cnt >= ETU * 21 / 2 && cnt < ETU * 23 / 2;
    end
endmodule

// ---- verif/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ETU = scs_pkg::CLK_PER_ETU * 2;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic standby = 1'b0;
    logic card_err = 1'b0;
    logic pull_low;
    scs_pkg::scs_req_s req = '0;
    logic [7:0] rdata, s, v;
    scs_pkg::scs_pin_s line_pin, sck_pin, p;
    wire line_in = (line_pin.oe ? line_pin.out : 1'b1) & ~pull_low;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    integer seed = 32'h8777471b;
    logic [2:0] cfg [6] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b110, 3'b111};

    scs_ctrl u_scs_ctrl (.sys_clk(sys_clk), .reset(reset), .standby(standby), .req(req), .rdata(rdata),
        .line_in(line_in), .line_pin(line_pin), .sck_pin(sck_pin));
    scs_card #(.ETU(ETU)) u_scs_card (.sys_clk(sys_clk), .line(line_in), .err_req(card_err),
        .pull_low(pull_low));

    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            give_verdict();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic upto(input int c);
        while (cyc - t0 < c) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [1:0] sck_exp(input logic [2:0] c);
        if (!c[2]) return {c[1:0] == 2'b01, 1'b0};
        return {1'b1, c[1]};
    endfunction
    task automatic chk_resets();
        rd(scs_pkg::ADDR_MODE, s);
        chk(s, scs_pkg::RST_MODE);
        rd(scs_pkg::ADDR_RATE, s);
        chk(s, scs_pkg::RST_RATE);
        rd(scs_pkg::ADDR_CTRL, s);
        chk(s, scs_pkg::RST_CTRL);
        rd(scs_pkg::ADDR_TXDATA, s);
        chk(s, scs_pkg::RST_TXDATA);
        rd(scs_pkg::ADDR_STAT, s);
        chk(s, 8'h84);
        rd(scs_pkg::ADDR_CARDMODE, s);
        chk(s, scs_pkg::RST_CARDMODE);
    endtask
    task automatic send(input logic gm, input logic err);
        logic [7:0] d;
        logic [9:0] f;
        int k;
        d = 8'($random(seed));
        f = {^d, d, 1'b0};
        wr(scs_pkg::ADDR_MODE, {gm, 7'h00});
        wr(scs_pkg::ADDR_TXDATA, d);
        wr(scs_pkg::ADDR_CTRL, 8'h21);
        card_err <= err;
        rd(scs_pkg::ADDR_STAT, s);
        chk(s, 8'h84);
        wr(scs_pkg::ADDR_STAT, 8'h00);
        k = 0;
        #1;
        while (!line_pin.oe && k < 20) begin
            @(posedge sys_clk);
            #1 k++;
        end
        t0 = cyc;
        for (k = 0; k < 10; k++) begin
            upto(ETU * k + ETU / 2);
            chk(8'({line_pin.oe, line_pin.out}), 8'({1'b1, f[k]}));
        end
        // line released after parity so the card can answer
        upto(ETU * 103 / 10);
        chk(8'(line_pin.oe), 8'h00);
        if (err) begin
            upto(ETU * 116 / 10);
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h90);
            // refused character goes out again with a new start bit
            upto(ETU * 145 / 10);
            chk(8'({line_pin.oe, line_pin.out}), 8'h02);
            wr(scs_pkg::ADDR_STAT, 8'hff);
            wr(scs_pkg::ADDR_STAT, 8'h00);
            wr(scs_pkg::ADDR_CTRL, 8'h01);
            card_err <= 1'b0;
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h90);
            wr(scs_pkg::ADDR_STAT, 8'h80);
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h84);
        end else begin
            upto(ETU * (gm ? 108 : 123) / 10);
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h80);
            upto(ETU * (gm ? 113 : 127) / 10);
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h84);
        end
        upto(ETU * 13);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        chk_resets();
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(scs_pkg::ADDR_RATE, v);
            rd(scs_pkg::ADDR_RATE, s);
            chk(s, v);
            wr(scs_pkg::ADDR_CTRL, v & 8'hfd);
            rd(scs_pkg::ADDR_CTRL, s);
            chk(s, v & 8'hfd & scs_pkg::CTRL_WMASK);
            wr(scs_pkg::ADDR_CARDMODE, v);
            rd(scs_pkg::ADDR_CARDMODE, s);
            chk(s, v & scs_pkg::CARDMODE_WMASK);
            wr(8'h14, v);
            rd(8'h14, s);
            chk(s, 8'h00);
            wr(scs_pkg::ADDR_STAT, 8'hff);
            rd(scs_pkg::ADDR_STAT, s);
            chk(s, 8'h84);
        end
        @(posedge sys_clk);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        chk_resets();
        wr(scs_pkg::ADDR_RATE, 8'h00);
        wr(scs_pkg::ADDR_CARDMODE, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(scs_pkg::ADDR_MODE, {cfg[i][2], 7'h00});
            wr(scs_pkg::ADDR_CTRL, {6'h00, cfg[i][1:0]});
            repeat (4) @(posedge sys_clk);
            #1 p = sck_pin;
            @(posedge sys_clk);
            #1;
            chk(8'(p.oe), 8'(sck_exp(cfg[i]) >> 1));
            if (p.oe) chk(8'(sck_pin.out), 8'(cfg[i][0] ? !p.out : sck_exp(cfg[i]) & 2'b01));
        end
        send(1'b1, 1'b0);
        send(1'b0, 1'b0);
        send(1'b1, 1'b1);
        give_verdict();
    end
endmodule
